// *** rtl/mhb_dev.sv ***
// Device end: samples host pins, decodes lanes per bus mode, emits access pulses.
// Assumes pins are asynchronous to I_CLK_SYS and the mode changes only while idle.
`timescale 1ns/1ps
module mhb_dev
  import mhb_pkg::*;
(
  input  wire logic                   I_CLK_SYS,
  input  wire logic                   I_SRST,
  input  wire mhb_mode_e              I_MODE,
  input  wire logic [MHB_DATA_W-1:0]  I_RD_DATA,
  mhb_pins_if.dev                     pins,
  output logic                        O_WR_STB,
  output logic                        O_RD_STB,
  output logic                        O_MEM_SEL,
  output logic [MHB_FULL_AW-1:0]      O_ADDR,
  output logic [1:0]                  O_LANE_EN,
  output logic [MHB_DATA_W-1:0]       O_WR_DATA
);

  localparam int NP = 6 + MHB_ADDR_W + MHB_DATA_W;

  logic [NP-1:0] s1_ff;
  logic [NP-1:0] s2_ff;
  logic [NP-1:0] s3_ff;
  logic [NP-1:0] pin_ff;
  logic [NP-1:0] raw;

  assign raw = {pins.cs_n, pins.mem_sel, pins.lowest_address_input,
                pins.low_byte_write_input, pins.high_byte_write_input, pins.read_n,
                pins.upper_address_inputs, pins.host_data_port_host_o};

  // Three-stage sampling; a bit changes once stages two and three agree.
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SRST) begin
      s1_ff  <= {NP{1'b1}};
      s2_ff  <= {NP{1'b1}};
      s3_ff  <= {NP{1'b1}};
      pin_ff <= {NP{1'b1}};
    end else begin
      s1_ff <= raw;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      for (int i = 0; i < NP; i++) begin
        if (s2_ff[i] == s3_ff[i]) begin
          pin_ff[i] <= s3_ff[i];
        end
      end
    end
  end

  logic                  cs_n;
  logic                  msel;
  logic                  a0;
  logic                  wl;
  logic                  wh;
  logic                  rd_n;
  logic [MHB_ADDR_W-1:0] ahi;
  logic [MHB_DATA_W-1:0] din;

  assign {cs_n, msel, a0, wl, wh, rd_n, ahi, din} = pin_ff;

  // Per mode: active write, active read and lane enables of the current cycle.
  logic       wr_act;
  logic       rd_act;
  logic [1:0] lanes;
  logic       lsb;

  always_comb begin
    wr_act = 1'b0;
    rd_act = 1'b0;
    lanes  = 2'b00;
    lsb    = 1'b0;
    unique case (I_MODE)
      MHB_DUAL_STROBE, MHB_BUS_START: begin
        lanes  = {~wh, ~wl};  // see RL7 see RL8
        wr_act = |lanes;
        rd_act = ~rd_n;
        if (rd_act) lanes = 2'b11;
      end
      MHB_BYTE_ENABLE: begin
        lsb    = a0;  // see RL3
        lanes  = {~wh, ~a0};  // see RL9
        wr_act = ~wl;
        rd_act = ~rd_n;
      end
      MHB_SPLIT_STROBE_ASYNC: begin
        lanes  = {~wh, ~a0};  // see RL4
        wr_act = |lanes;
        rd_act = 1'b0;
      end
      MHB_SIZED_ASYNC: begin
        lsb    = a0;  // see RL3
        wr_act = ~wh;  // see RL10
        // Size bit zero set means a single byte at the lane picked by A0.
        lanes  = wl ? (a0 ? 2'b01 : 2'b10) : 2'b11;  // see RL10
      end
      MHB_BYTE_ENABLE_OE_A, MHB_BYTE_ENABLE_OE_B: begin
        lanes  = {~wh, ~wl};  // see RL11
        // Enabled lanes with the output enable low are a read, not a write.
        wr_act = |lanes & rd_n;
        rd_act = ~rd_n;
      end
      default: begin
        lanes = 2'b00;
      end
    endcase
  end

  logic sel;
  logic busy_ff;
  logic rd_hold_ff;

  assign sel = ~cs_n;  // see RL13

  // One pulse per access; a new access needs the strobes released or chip select dropped first.
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SRST) begin
      busy_ff   <= 1'b0;
      O_WR_STB  <= 1'b0;
      O_RD_STB  <= 1'b0;
      O_MEM_SEL <= 1'b0;
      O_ADDR    <= '0;
      O_LANE_EN <= 2'b00;
      O_WR_DATA <= '0;
    end else begin
      O_WR_STB <= 1'b0;
      O_RD_STB <= 1'b0;
      if (!sel || !(wr_act || rd_act)) begin
        busy_ff <= 1'b0;
      end else if (!busy_ff) begin
        busy_ff   <= 1'b1;
        O_WR_STB  <= wr_act;
        O_RD_STB  <= rd_act & ~wr_act;
        O_MEM_SEL <= msel;  // see RL1
        O_ADDR    <= {ahi, lsb};  // see RL2
        O_LANE_EN <= lanes;
        O_WR_DATA <= din;  // see RL12
      end
    end
  end

  // Drive the data port only while selected and a read is under way.
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SRST) begin
      rd_hold_ff <= 1'b0;
    end else begin
      rd_hold_ff <= sel & rd_act & ~wr_act;  // see RL13
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (I_SRST) begin
      pins.host_data_port_dev_o <= '0;
    end else if (sel && rd_act) begin
      pins.host_data_port_dev_o <= I_RD_DATA;
    end
  end

  assign pins.host_data_port_dev_oe_n = ~(rd_hold_ff & sel & rd_act);  // see RL13

endmodule : mhb_dev

// *** rtl/mhb_pkg.sv ***
// Package for the multi-mode host bus pin decoder and its host-side driver.
// Assumes one 20 MHz system clock shared by both ends.
// Operation
// RL1: Select pin high means buffer, low registers.
// RL2: Sixteen upper address inputs carry bits 16..1.
// RL3: Byte-enable and sized modes use lowest address bit.
// RL4: Split-strobe mode: lowest address and high-write strobe lanes.
// RL5: Host grounds lowest address in four modes.
// RL6: Split-strobe mode: host holds low write high.
// RL7: Dual-strobe mode: two per-lane write strobes.
// RL8: Bus-start mode: writes strobe byte zero, one.
// RL9: Byte-enable mode: one strobe plus high enable.
// RL10: Sized mode: low write is size, high strobe.
// RL11: Output-enable modes: per-lane active enables.
// RL12: Data port on D[31:16] for 32-bit sized hosts.
// RL13: Nothing acts unless chip select asserted.
package mhb_pkg;

  typedef enum logic [2:0] {
    MHB_DUAL_STROBE,
    MHB_BYTE_ENABLE,
    MHB_BUS_START,
    MHB_SPLIT_STROBE_ASYNC,
    MHB_SIZED_ASYNC,
    MHB_BYTE_ENABLE_OE_A,
    MHB_BYTE_ENABLE_OE_B
  } mhb_mode_e;

  localparam int MHB_ADDR_W  = 16;
  localparam int MHB_DATA_W  = 16;
  localparam int MHB_LANE_W  = 8;
  localparam int MHB_SYNC_W  = 3;
  localparam int MHB_FULL_AW = 17;

endpackage : mhb_pkg

// *** rtl/mhb_pins_if.sv ***
// Pin bundle between the host driver and the device decoder.
// Assumes the testbench resolves the data wire from the output enables.
`timescale 1ns/1ps
interface mhb_pins_if;
  import mhb_pkg::*;
  logic                  cs_n;
  logic                  mem_sel;
  logic [MHB_ADDR_W-1:0] upper_address_inputs;
  logic                  lowest_address_input;
  logic                  low_byte_write_input;
  logic                  high_byte_write_input;
  logic                  read_n;
  logic [MHB_DATA_W-1:0] host_data_port_host_o;
  logic                  host_data_port_host_oe_n;
  logic [MHB_DATA_W-1:0] host_data_port_dev_o;
  logic                  host_data_port_dev_oe_n;

  modport dev (
    input  cs_n, mem_sel, upper_address_inputs, lowest_address_input,
    input  low_byte_write_input, high_byte_write_input, read_n,
    input  host_data_port_host_o, host_data_port_host_oe_n,
    output host_data_port_dev_o, host_data_port_dev_oe_n
  );

  modport host (
    output cs_n, mem_sel, upper_address_inputs, lowest_address_input,
    output low_byte_write_input, high_byte_write_input, read_n,
    output host_data_port_host_o, host_data_port_host_oe_n,
    input  host_data_port_dev_o, host_data_port_dev_oe_n
  );
endinterface : mhb_pins_if

// *** rtl/mhb_host.sv ***
// Host end: turns a simple request into pin activity in the chosen bus mode.
// Assumes the device mode input equals I_MODE and is changed only while idle.
`timescale 1ns/1ps
module mhb_host
  import mhb_pkg::*;
#(
  parameter int unsigned HOLD_CYC = 6
) (
  input  wire logic                   I_CLK_SYS,
  input  wire logic                   I_SRST,
  input  wire mhb_mode_e              I_MODE,
  input  wire logic                   I_REQ,
  input  wire logic                   I_WRITE,
  input  wire logic                   I_MEM_SEL,
  input  wire logic [MHB_FULL_AW-1:0] I_ADDR,
  input  wire logic [1:0]             I_LANES,
  input  wire logic [MHB_DATA_W-1:0]  I_WR_DATA,
  mhb_pins_if.host                    pins,
  output logic                        O_READY,
  output logic                        O_DONE,
  output logic [MHB_DATA_W-1:0]       O_RD_DATA
);

  typedef enum logic [1:0] {ST_IDLE, ST_STROBE, ST_RECOVER} mhb_hst_e;

  mhb_hst_e    st_ff;
  logic [7:0]  cnt_ff;
  logic        wr_ff;
  logic [1:0]  ln_ff;
  logic        a0_ff;

  assign O_READY = (st_ff == ST_IDLE);

  always_ff @(posedge I_CLK_SYS) begin
    if (I_SRST) begin
      st_ff                         <= ST_IDLE;
      cnt_ff                        <= 8'h00;
      wr_ff                         <= 1'b0;
      ln_ff                         <= 2'b00;
      a0_ff                         <= 1'b0;
      O_DONE                        <= 1'b0;
      O_RD_DATA                     <= '0;
      pins.mem_sel                  <= 1'b0;
      pins.upper_address_inputs     <= '0;
      pins.host_data_port_host_o    <= '0;
    end else begin
      O_DONE <= 1'b0;
      unique case (st_ff)
        ST_IDLE: begin
          if (I_REQ) begin
            st_ff                      <= ST_STROBE;
            cnt_ff                     <= 8'(HOLD_CYC);
            wr_ff                      <= I_WRITE;
            ln_ff                      <= I_LANES;
            a0_ff                      <= I_ADDR[0];
            pins.mem_sel               <= I_MEM_SEL;  // see RL1
            pins.upper_address_inputs  <= I_ADDR[MHB_FULL_AW-1:1];  // see RL2
            pins.host_data_port_host_o <= I_WR_DATA;  // see RL12
          end
        end
        ST_STROBE: begin
          if (cnt_ff == 8'h00) begin
            st_ff     <= ST_RECOVER;
            cnt_ff    <= 8'(HOLD_CYC);
            O_RD_DATA <= pins.host_data_port_dev_o;
          end else begin
            cnt_ff <= cnt_ff - 8'h01;
          end
        end
        ST_RECOVER: begin
          if (cnt_ff == 8'h00) begin
            st_ff  <= ST_IDLE;
            O_DONE <= 1'b1;
          end else begin
            cnt_ff <= cnt_ff - 8'h01;
          end
        end
        default: st_ff <= ST_IDLE;
      endcase
    end
  end

  logic act;
  logic w;
  logic r;
  logic a0_pin;
  logic wl_pin;
  logic wh_pin;
  logic rd_pin;

  assign act = (st_ff == ST_STROBE);
  assign w   = act & wr_ff;
  assign r   = act & ~wr_ff;

  always_comb begin
    a0_pin = 1'b0;  // see RL5
    wl_pin = 1'b1;
    wh_pin = 1'b1;
    rd_pin = ~r;
    unique case (I_MODE)
      MHB_DUAL_STROBE, MHB_BUS_START: begin
        wl_pin = ~(w & ln_ff[0]);  // see RL7 see RL8
        wh_pin = ~(w & ln_ff[1]);
      end
      // Lane enables qualify reads as well as writes in these modes.
      MHB_BYTE_ENABLE_OE_A, MHB_BYTE_ENABLE_OE_B: begin
        wl_pin = ~(act & ln_ff[0]);  // see RL11
        wh_pin = ~(act & ln_ff[1]);
      end
      MHB_BYTE_ENABLE: begin
        a0_pin = a0_ff;  // see RL3
        wl_pin = ~w;  // see RL9
        wh_pin = ~(act & ln_ff[1]);
      end
      MHB_SPLIT_STROBE_ASYNC: begin
        a0_pin = ~(w & ln_ff[0]);  // see RL4
        wl_pin = 1'b1;  // see RL6
        wh_pin = ~(w & ln_ff[1]);
        rd_pin = 1'b1;
      end
      MHB_SIZED_ASYNC: begin
        a0_pin = a0_ff;  // see RL3
        wl_pin = ~(&ln_ff);  // see RL10
        wh_pin = ~w;
        rd_pin = 1'b1;
      end
      default: begin
        rd_pin = 1'b1;
      end
    endcase
  end

  assign pins.cs_n                     = ~act;  // see RL13
  assign pins.lowest_address_input     = a0_pin;
  assign pins.low_byte_write_input     = wl_pin;
  assign pins.high_byte_write_input    = wh_pin;
  assign pins.read_n                   = rd_pin;
  assign pins.host_data_port_host_oe_n = ~w;

endmodule : mhb_host

// *** sim/mhb_chk.sv ***
// Checker on the pin bundle between the host end and the device end.
// Assumes the host end runs with HOLD_CYC of 6 and one system clock.
`timescale 1ns/1ps
module mhb_chk
  import mhb_pkg::*;
(
  input wire logic                  I_CLK_SYS,
  input wire logic                  I_SRST,
  input wire mhb_mode_e             I_MODE,
  input wire logic                  cs_n,
  input wire logic                  mem_sel,
  input wire logic [MHB_ADDR_W-1:0] upper_address_inputs,
  input wire logic                  lowest_address_input,
  input wire logic                  low_byte_write_input,
  input wire logic                  high_byte_write_input,
  input wire logic                  read_n,
  input wire logic                  host_data_port_host_oe_n,
  input wire logic                  host_data_port_dev_oe_n
);
  default clocking @(posedge I_CLK_SYS); endclocking
  default disable iff (I_SRST);
  chk_idle_no_drive: assert property (cs_n [*6] |-> host_data_port_dev_oe_n)
    else $error("device drives data while deselected");
  chk_no_collide: assert property (!(!host_data_port_host_oe_n && !host_data_port_dev_oe_n))
    else $error("both ends drive the data port");
  chk_split_low_high: assert property (I_MODE == MHB_SPLIT_STROBE_ASYNC |-> low_byte_write_input)
    else $error("low write input not held high in split mode");
  chk_a0_grounded: assert property (I_MODE inside {MHB_DUAL_STROBE, MHB_BUS_START,
    MHB_BYTE_ENABLE_OE_A, MHB_BYTE_ENABLE_OE_B} && !cs_n |-> !lowest_address_input)
    else $error("lowest address input not grounded");
  chk_strobe_framed: assert property (!high_byte_write_input |-> !cs_n)
    else $error("strobe active without chip select");
  chk_strobe_width: assert property ($fell(cs_n) |-> !cs_n [*7] ##1 cs_n)
    else $error("select phase length wrong");
  chk_recover_gap: assert property ($rose(cs_n) |-> cs_n [*7])
    else $error("recovery gap too short");
  chk_read_drive: assert property (I_MODE == MHB_DUAL_STROBE && !cs_n && $fell(read_n)
    |-> ##[3:8] !host_data_port_dev_oe_n)
    else $error("device did not drive read data");
  chk_addr_held: assert property (!cs_n && !$past(cs_n)
    |-> $stable(upper_address_inputs) && $stable(mem_sel))
    else $error("address or space select moved in a cycle");
  cover property ($fell(read_n));
  cover property ($fell(cs_n) && I_MODE == MHB_SIZED_ASYNC);
  cover property (!cs_n && I_MODE == MHB_SPLIT_STROBE_ASYNC);
endmodule // mhb_chk

// *** sim/tb.sv ***
// Bench: host end and device end joined by the pin bundle, plus a spare device end.
// Assumes the package, interface and both design ends compile first.
`timescale 1ns/1ps
module tb;
  import mhb_pkg::*;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  mhb_mode_e   mode = MHB_DUAL_STROBE;
  mhb_mode_e   m;
  logic        req = 1'b0, wr = 1'b0, ms = 1'b0, w;
  logic [16:0] addr = '0, a, oaddr;
  logic [1:0]  ln = 2'h3, l, olane;
  logic [15:0] wd = '0, rd = '0, owd, ord;
  logic        rdy, done, wstb, rstb, msel, wstb2, rstb2;
  int          miscompares = 0, tests_run = 0, nw = 0, nr = 0, nw2 = 0, n;
  mhb_pins_if pins();
  mhb_pins_if pins2();
  always #25 clk = ~clk;
  always @(posedge clk) begin
    nw <= nw + int'(wstb);
    nr <= nr + int'(rstb);
    nw2 <= nw2 + int'(wstb2) + int'(rstb2);
  end
  mhb_host i_mhb_host (.I_CLK_SYS(clk), .I_SRST(srst), .I_MODE(mode), .I_REQ(req),
    .I_WRITE(wr), .I_MEM_SEL(ms), .I_ADDR(addr), .I_LANES(ln), .I_WR_DATA(wd),
    .pins(pins.host), .O_READY(rdy), .O_DONE(done), .O_RD_DATA(ord));
  mhb_dev i_mhb_dev (.I_CLK_SYS(clk), .I_SRST(srst), .I_MODE(mode), .I_RD_DATA(rd),
    .pins(pins.dev), .O_WR_STB(wstb), .O_RD_STB(rstb), .O_MEM_SEL(msel), .O_ADDR(oaddr),
    .O_LANE_EN(olane), .O_WR_DATA(owd));
  mhb_dev i_mhb_dev_b (.I_CLK_SYS(clk), .I_SRST(srst), .I_MODE(mode), .I_RD_DATA(rd),
    .pins(pins2.dev), .O_WR_STB(wstb2), .O_RD_STB(rstb2), .O_MEM_SEL(), .O_ADDR(),
    .O_LANE_EN(), .O_WR_DATA());
  mhb_chk i_mhb_chk (.I_CLK_SYS(clk), .I_SRST(srst), .I_MODE(mode), .cs_n(pins.cs_n),
    .mem_sel(pins.mem_sel), .upper_address_inputs(pins.upper_address_inputs),
    .lowest_address_input(pins.lowest_address_input),
    .low_byte_write_input(pins.low_byte_write_input),
    .high_byte_write_input(pins.high_byte_write_input), .read_n(pins.read_n),
    .host_data_port_host_oe_n(pins.host_data_port_host_oe_n),
    .host_data_port_dev_oe_n(pins.host_data_port_dev_oe_n));

  function automatic logic [1:0] exp_lanes(mhb_mode_e em, logic ew, logic [1:0] el);
    return (!ew && (em == MHB_DUAL_STROBE || em == MHB_BUS_START)) ? 2'h3 : el;
  endfunction

  task automatic check(string what, logic [16:0] seen, logic [16:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic results;
    $display("Checks %0d miscompares %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic xfer;
    int c0;
    int c1;
    logic [15:0] msk;
    c0 = nw;
    c1 = nr;
    msk = {{8{l[1]}}, {8{l[0]}}};
    mode = m;
    wr = w;
    ln = l;
    addr = a;
    ms = 1'($urandom);
    wd = 16'($urandom);
    rd = 16'($urandom);
    req = 1'b1;
    @(negedge clk);
    req = 1'b0;
    check("ready busy", {16'h0, rdy}, 17'h0);
    n = 0;
    while (done !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    check("done latency", 17'(n), 17'(2 * 6 + 2));
    check("ready idle", {16'h0, rdy}, 17'h1);
    check("access pulses", 17'(w ? nw - c0 : nr - c1), 17'h1);
    check("space select", {16'h0, msel}, {16'h0, ms});
    check("upper address", {1'b0, oaddr[16:1]}, {1'b0, a[16:1]});
    check("addr bit0", {16'h0, oaddr[0]}, {16'h0, a[0]});
    check("lanes", {15'h0, olane}, {15'h0, exp_lanes(m, w, l)});
    check("data", {1'b0, (w ? owd : ord) & msk}, {1'b0, (w ? wd : rd) & msk});
    @(negedge clk);
  endtask

  task automatic spare(logic sel_n, logic [16:0] exp);
    int c0;
    c0 = nw2;
    pins2.cs_n = sel_n;
    pins2.low_byte_write_input = 1'b0;
    pins2.read_n = ~sel_n;
    repeat (10) @(negedge clk);
    check("spare drive", {16'h0, pins2.host_data_port_dev_oe_n}, 17'h1);
    pins2.cs_n = 1'b1;
    pins2.low_byte_write_input = 1'b1;
    pins2.read_n = 1'b1;
    repeat (10) @(negedge clk);
    check("spare pulses", 17'(nw2 - c0), exp);
  endtask

  initial begin
    n = $urandom(32'hcfd1);
    pins2.cs_n = 1'b1;
    pins2.mem_sel = 1'b0;
    pins2.upper_address_inputs = '0;
    pins2.lowest_address_input = 1'b0;
    pins2.low_byte_write_input = 1'b1;
    pins2.high_byte_write_input = 1'b1;
    pins2.read_n = 1'b1;
    pins2.host_data_port_host_o = '0;
    pins2.host_data_port_host_oe_n = 1'b1;
    repeat (20) @(negedge clk);
    srst = 1'b0;
    for (int i = 0; i < 140; i++) begin
      m = mhb_mode_e'(i % 7);
      w = (m == MHB_SPLIT_STROBE_ASYNC || m == MHB_SIZED_ASYNC) ? 1'b1 : 1'($urandom);
      l = 2'($urandom % 3 + 1);
      a = (i < 7) ? 17'h1fffe : (i < 14) ? 17'h0 : 17'($urandom);
      // Sized single-byte cycles pick the low lane with an odd address.
      a[0] = (m == MHB_BYTE_ENABLE && l == 2'h2) || (m == MHB_SIZED_ASYNC && l == 2'h1);
      xfer();
    end
    spare(1'b1, 17'h0);
    spare(1'b0, 17'h1);
    results();
  end

  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    results();
  end
endmodule // tb
